// >>> src/pis_phase2_sequencer.sv
// Contract
// - Nibbles go out in ascending order, D1 first.
// - Each nibble sends identifier then value, k times.
// - 32 nibbles normally, 48 when extended.
// - D2 and D3 carry the block count.
// - Asynchronous 228 us mode repeats each nibble 8 times.
// - Synchronous 500 us mode repeats each nibble 4 times.
// - At most one transmission per slot tick; the code queues none in a slot where the FIFO still refuses the pending word.
// - Values come from user, serial and part registers.
// - Reserved extended positions send a fixed constant.
// - Start only after entry window passes undetected.
// - Async sends source 0 only; sync sends source 0 plus every other enabled source.
`include "pis_defs.svh"

module pis_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             clk_en_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    cnt_ff;
    logic             push;
    logic             pop;
    logic             load;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    // The head sits in a register so out_valid_o and out_data_o come from flops.
    assign in_ready_o = (cnt_ff != CW'(DEPTH));
    assign push       = in_valid_i && in_ready_o;
    assign load       = (!out_valid_o || out_ready_i) && (cnt_ff != '0);
    assign pop        = load;

    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            cnt_ff      <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (clk_en_i) begin
            if (push) begin
                wr_ptr_ff <= bump(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= bump(rd_ptr_ff);
            end
            cnt_ff <= CW'(cnt_ff + CW'(push) - CW'(pop));
            if (load) begin
                out_valid_o <= 1'b1;
                out_data_o  <= mem[rd_ptr_ff];
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule : pis_fifo

module pis_phase2_sequencer #(
    parameter logic [3:0] RSVD_NIBBLE = 4'h0,
    parameter int         FIFO_DEPTH  = 8
) (
    input  wire logic            core_clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            clk_en_i,
    input  wire logic            pme_window_done_i,
    input  wire logic            pme_detected_i,
    input  wire logic            sync_mode_i,
    input  wire logic            extended_phase2_enable_i,
    input  wire logic            slot_tick_i,
    input  wire logic [1:0]      slot_src_i,
    input  wire logic [3:0]      src_enable_i,
    input  wire logic [8:0][7:0] user_byte_i,
    input  wire logic [4:0][7:0] serial_i,
    input  wire logic [1:0][7:0] part_i,
    output logic                 tx_valid_o,
    output pis_pkg::pis_word_s   tx_word_o,
    input  wire logic            tx_ready_i,
    output logic                 busy_o,
    output logic                 done_o,
    output logic                 aborted_o,
    output logic                 slot_missed_o
);
    pis_pkg::pis_seq_s  s_ff;
    pis_pkg::pis_seq_s  nxt_s;
    logic               fifo_ready;
    logic               tick0;
    logic               adv;
    logic [3:0]         k_max;
    logic [5:0]         n_last;

    // Nibble value for sequence position idx (0 is D1).
    function automatic logic [3:0] nib_val(input logic [5:0] idx, input logic ext,
                                           input logic [8:0][7:0] u, input logic [4:0][7:0] sn,
                                           input logic [1:0][7:0] pn);
        logic [3:0] v;
        v = RSVD_NIBBLE;
        unique case (idx)
            6'h00: v = u[0][3:0];
            6'h01: v = ext ? `PIS_BLK_HI_EXT : `PIS_BLK_HI_STD;
            6'h02: v = `PIS_BLK_LO;
            6'h03: v = u[1][3:0];
            6'h04: v = u[1][7:4];
            6'h05: v = u[2][3:0];
            6'h06: v = u[2][7:4];
            6'h07: v = u[3][3:0];
            6'h08: v = u[3][7:4];
            6'h09: v = u[4][3:0];
            6'h0A: v = u[4][7:4];
            6'h0B: v = u[5][3:0];
            6'h0C: v = u[5][7:4];
            6'h0D: v = u[6][3:0];
            6'h0E: v = u[7][3:0];
            6'h0F: v = u[7][7:4];
            6'h10: v = u[8][3:0];
            6'h11: v = u[8][7:4];
            6'h12: v = sn[4][7:4];
            6'h13: v = sn[4][3:0];
            6'h14: v = sn[3][7:4];
            6'h15: v = sn[3][3:0];
            6'h16: v = sn[2][7:4];
            6'h17: v = sn[2][3:0];
            6'h18: v = sn[1][7:4];
            6'h19: v = sn[1][3:0];
            6'h1A: v = sn[0][7:4];
            6'h1B: v = sn[0][3:0];
            6'h1C: v = pn[1][3:0];
            6'h1D: v = pn[0][7:4];
            6'h1E: v = pn[0][3:0];
            6'h1F: v = u[6][7:4];
            default: v = RSVD_NIBBLE;
        endcase
        return v;
    endfunction : nib_val

    assign tick0  = slot_tick_i && (slot_src_i == 2'h0);
    assign k_max  = s_ff.sync ? (`PIS_K_SYNC - 4'h1) : (`PIS_K_ASYNC - 4'h1);
    assign n_last = s_ff.ext ? (`PIS_NIB_EXT - 6'h01) : (`PIS_NIB_STD - 6'h01);
    // A pending word that the FIFO still refuses costs the slot; the sequence then retries.
    assign adv    = (s_ff.st == pis_pkg::PIS_RUN) && tick0 && !(s_ff.pend && !fifo_ready);

    always_comb begin
        nxt_s = s_ff;
        if (s_ff.pend && fifo_ready) begin
            nxt_s.pend = 1'b0;
        end
        unique case (s_ff.st)
            pis_pkg::PIS_WAIT: begin
                if (pme_window_done_i) begin
                    nxt_s.st      = pme_detected_i ? pis_pkg::PIS_HALT : pis_pkg::PIS_RUN;
                    nxt_s.sync    = sync_mode_i;
                    nxt_s.ext     = extended_phase2_enable_i;
                    nxt_s.idx     = `PIS_IDX_RST;
                    nxt_s.rep     = `PIS_REP_RST;
                    nxt_s.half    = 1'b0;
                    nxt_s.started = 1'b0;
                end
            end
            pis_pkg::PIS_RUN, pis_pkg::PIS_FINISH: begin
                if (slot_tick_i && s_ff.pend && !fifo_ready) begin
                    nxt_s.miss = 1'b1;
                end else if (adv) begin
                    nxt_s.word.is_data = s_ff.half;
                    nxt_s.word.page    = s_ff.idx[5:4];
                    nxt_s.word.id      = s_ff.idx[3:0];
                    nxt_s.word.nibble  = s_ff.half ? nib_val(s_ff.idx, s_ff.ext, user_byte_i, serial_i, part_i)
                                                   : s_ff.idx[3:0];
                    nxt_s.word.src     = 2'h0;
                    nxt_s.last         = nxt_s.word;
                    nxt_s.pend         = 1'b1;
                    nxt_s.started      = 1'b1;
                    nxt_s.half         = !s_ff.half;
                    if (s_ff.half) begin
                        if (s_ff.rep == k_max) begin
                            nxt_s.rep = `PIS_REP_RST;
                            if (s_ff.idx == n_last) begin
                                nxt_s.st = pis_pkg::PIS_FINISH;
                            end else begin
                                nxt_s.idx = 6'(s_ff.idx + 6'h01);
                            end
                        end else begin
                            nxt_s.rep = 4'(s_ff.rep + 4'h1);
                        end
                    end
                end else if (tick0) begin
                    nxt_s.st = pis_pkg::PIS_DONE;
                end else if (slot_tick_i && s_ff.sync && s_ff.started && src_enable_i[slot_src_i]) begin
                    // Other enabled sources repeat what source 0 sent this period.
                    nxt_s.word     = s_ff.last;
                    nxt_s.word.src = slot_src_i;
                    nxt_s.pend     = 1'b1;
                end
            end
            pis_pkg::PIS_DONE, pis_pkg::PIS_HALT: begin
            end
            default: nxt_s.st = pis_pkg::PIS_WAIT;
        endcase
        // Status is decoded from the next state so every output leaves straight from a flop.
        nxt_s.busy    = (nxt_s.st == pis_pkg::PIS_RUN) || (nxt_s.st == pis_pkg::PIS_FINISH);
        nxt_s.done    = (nxt_s.st == pis_pkg::PIS_DONE);
        nxt_s.aborted = (nxt_s.st == pis_pkg::PIS_HALT);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff <= '{st: pis_pkg::PIS_WAIT, idx: `PIS_IDX_RST, rep: `PIS_REP_RST, default: '0};
        end else if (clk_en_i) begin
            s_ff <= nxt_s;
        end
    end

    pis_fifo #(
        .WIDTH ($bits(pis_pkg::pis_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .clk_en_i    (clk_en_i),
        .in_valid_i  (s_ff.pend),
        .in_data_i   (s_ff.word),
        .in_ready_o  (fifo_ready),
        .out_valid_o (tx_valid_o),
        .out_data_o  (tx_word_o),
        .out_ready_i (tx_ready_i)
    );

    assign busy_o        = s_ff.busy;
    assign done_o        = s_ff.done;
    assign aborted_o     = s_ff.aborted;
    assign slot_missed_o = s_ff.miss;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_order;
        clk_en_i && adv && s_ff.half && s_ff.rep == k_max && s_ff.idx != n_last
            |=> s_ff.idx == 6'($past(s_ff.idx) + 6'h01) && !s_ff.half;
    endproperty
    a_order: assert property (p_order) else $error("nibble index did not step by one");

    property p_pair;
        clk_en_i && adv && !s_ff.half |=> s_ff.pend && !s_ff.word.is_data && s_ff.half
            && s_ff.idx == $past(s_ff.idx);
    endproperty
    a_pair: assert property (p_pair) else $error("identifier slot not followed by value slot");

    property p_count;
        s_ff.st == pis_pkg::PIS_FINISH |-> s_ff.idx == (s_ff.ext ? 6'h2F : 6'h1F);
    endproperty
    a_count: assert property (p_count) else $error("sequence ended at wrong nibble");

    property p_block;
        s_ff.pend && s_ff.word.is_data && s_ff.word.page == 2'h0 && s_ff.word.id == 4'h1
            |-> s_ff.word.nibble == (s_ff.ext ? 4'h3 : 4'h2);
    endproperty
    a_block: assert property (p_block) else $error("block count nibble wrong");

    property p_k_async;
        clk_en_i && adv && s_ff.half && !s_ff.sync && s_ff.rep == 4'h7 |=> s_ff.rep == 4'h0;
    endproperty
    a_k_async: assert property (p_k_async) else $error("async repetition not eight");

    property p_k_sync;
        busy_o && s_ff.sync |-> s_ff.rep <= 4'h3;
    endproperty
    a_k_sync: assert property (p_k_sync) else $error("sync repetition above four");

    property p_slot;
        $rose(s_ff.pend) |-> $past(slot_tick_i);
    endproperty
    a_slot: assert property (p_slot) else $error("word queued outside a slot");

    property p_serial;
        s_ff.pend && s_ff.word.is_data && s_ff.word.page == 2'h1 && s_ff.word.id == 4'h2
            |-> s_ff.word.nibble == serial_i[4][7:4];
    endproperty
    a_serial: assert property (p_serial) else $error("serial nibble wrong");

    property p_rsvd;
        s_ff.pend && s_ff.word.is_data && s_ff.word.page == 2'h2 |-> s_ff.word.nibble == RSVD_NIBBLE;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved nibble not constant");

    property p_start;
        s_ff.st == pis_pkg::PIS_RUN && $past(s_ff.st) == pis_pkg::PIS_WAIT
            |-> $past(pme_window_done_i) && !$past(pme_detected_i);
    endproperty
    a_start: assert property (p_start) else $error("phase started without clean entry window");

    property p_src;
        s_ff.pend && !s_ff.sync |-> s_ff.word.src == 2'h0;
    endproperty
    a_src: assert property (p_src) else $error("async word for nonzero source");

    property p_ident;
        s_ff.pend && !s_ff.word.is_data |-> s_ff.word.id == s_ff.idx[3:0] && s_ff.word.page == s_ff.idx[5:4];
    endproperty
    a_ident: assert property (p_ident) else $error("identifier or page wrong");

    property p_low_first;
        s_ff.pend && s_ff.word.is_data && s_ff.word.page == 2'h0 && s_ff.word.id == 4'h3
            |-> s_ff.word.nibble == user_byte_i[1][3:0];
    endproperty
    a_low_first: assert property (p_low_first) else $error("user byte high nibble sent first");
endmodule : pis_phase2_sequencer

// >>> src/pis_defs.svh
`ifndef PIS_DEFS_SVH
`define PIS_DEFS_SVH

// Repetition count per nibble in each operating mode.
`define PIS_K_ASYNC      4'h8
`define PIS_K_SYNC       4'h4
// Nibble counts of the standard and the extended sequence.
`define PIS_NIB_STD      6'h20
`define PIS_NIB_EXT      6'h30
// Block-count field: high nibble first (D2), then low nibble (D3).
`define PIS_BLK_HI_STD   4'h2
`define PIS_BLK_HI_EXT   4'h3
`define PIS_BLK_LO       4'h0
// Slot periods in microseconds; the slot tick itself comes from outside.
`define PIS_T_ASYNC_US   228
`define PIS_T_SYNC_US    500
// Reset values.
`define PIS_IDX_RST      6'h00
`define PIS_REP_RST      4'h0

`endif

// >>> src/pis_pkg.sv
package pis_pkg;

    typedef enum logic [2:0] {
        PIS_WAIT,
        PIS_RUN,
        PIS_FINISH,
        PIS_DONE,
        PIS_HALT
    } pis_state_e;

    typedef struct packed {
        logic       is_data;
        logic [1:0] page;
        logic [3:0] id;
        logic [3:0] nibble;
        logic [1:0] src;
    } pis_word_s;

    typedef struct packed {
        pis_state_e st;
        logic       sync;
        logic       ext;
        logic [5:0] idx;
        logic [3:0] rep;
        logic       half;
        logic       started;
        logic       pend;
        pis_word_s  word;
        pis_word_s  last;
        logic       miss;
        logic       busy;
        logic       done;
        logic       aborted;
    } pis_seq_s;

endpackage : pis_pkg

// >>> tb/pis_rx_model.sv
// Control-unit receiver. It accepts words at once, or only every other cycle
// when slow, and refuses everything while stalled so the FIFO fills up.
module pis_rx_model (
    input  wire logic               core_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               stall_i,
    input  wire logic               slow_i,
    input  wire logic               tx_valid_i,
    input  wire pis_pkg::pis_word_s tx_word_i,
    output logic                    tx_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;

    pis_pkg::pis_word_s got[$];
    logic               phase;

    initial begin
        tx_ready_o = 1'b0;
        phase = 1'b0;
    end

    always @(posedge core_clk_i) begin
        if (rst_n_i && tx_valid_i && tx_ready_o) begin
            got.push_back(tx_word_i);
        end
        #2;
        phase = ~phase;
        tx_ready_o = rst_n_i && !stall_i && !(slow_i && phase);
    end
endmodule : pis_rx_model

// >>> tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 win = 1'b0;
    logic                 det = 1'b0;
    logic                 sy = 1'b0;
    logic                 ex = 1'b0;
    logic                 tck = 1'b0;
    logic [1:0]           src = 2'h0;
    logic                 stall = 1'b0;
    logic                 slow = 1'b0;
    logic [8:0][7:0]      ub = 72'h98_76_54_32_10_FE_DC_BA_A5;
    logic [4:0][7:0]      sn = 40'h13_57_9B_DF_24;
    logic [1:0][7:0]      pn = 16'hC6_E8;
    logic                 tx_valid;
    logic                 tx_ready;
    logic                 busy;
    logic                 done;
    logic                 aborted;
    logic                 missed;
    pis_pkg::pis_word_s   tx_word;
    int                   miscompares = 0;
    int                   samples_checked = 0;

    always #12.5 clk = ~clk;

    pis_phase2_sequencer #(.RSVD_NIBBLE(4'h0), .FIFO_DEPTH(8)) uut (
        .core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .pme_window_done_i(win),
        .pme_detected_i(det), .sync_mode_i(sy), .extended_phase2_enable_i(ex),
        .slot_tick_i(tck), .slot_src_i(src), .src_enable_i(4'h2), .user_byte_i(ub),
        .serial_i(sn), .part_i(pn), .tx_valid_o(tx_valid), .tx_word_o(tx_word),
        .tx_ready_i(tx_ready), .busy_o(busy), .done_o(done), .aborted_o(aborted),
        .slot_missed_o(missed));

    pis_rx_model rx (
        .core_clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .slow_i(slow),
        .tx_valid_i(tx_valid), .tx_word_i(tx_word), .tx_ready_o(tx_ready));

    task automatic final_report;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Nibble value for position i (0 is D1), as the device must send it.
    function automatic logic [3:0] nib(input int i);
        int b;
        if (i == 0) return ub[0][3:0];
        if (i == 1) return ex ? 4'h3 : 4'h2;
        if (i == 2 || i >= 32) return 4'h0;
        if (i == 13) return ub[6][3:0];
        if (i == 31) return ub[6][7:4];
        if (i == 28) return pn[1][3:0];
        if (i == 29) return pn[0][7:4];
        if (i == 30) return pn[0][3:0];
        if (i >= 18) begin
            b = 4 - (i - 18) / 2;
            return i[0] ? sn[b][3:0] : sn[b][7:4];
        end
        b = (i <= 12) ? (i - 1) / 2 : i / 2;
        return (i[0] == (i <= 12)) ? ub[b][3:0] : ub[b][7:4];
    endfunction : nib

    function automatic logic [15:0] ew(input int j, input int k);
        int i;
        i = j / (2 * k);
        return {3'h0, j[0], i[5:4], i[3:0], j[0] ? nib(i) : i[3:0], 2'h0};
    endfunction : ew

    task automatic tick(input logic [1:0] s);
        @(posedge clk) #2;
        tck = 1'b1;
        src = s;
        @(posedge clk) #2;
        tck = 1'b0;
        repeat (3) @(posedge clk);
    endtask : tick

    task automatic do_reset;
        #2;
        rst_n = 1'b0;
        win = 1'b0;
        repeat (5) @(posedge clk);
        #2;
        rst_n = 1'b1;
        rx.got.delete();
    endtask : do_reset

    task automatic start;
        tick(2'h1);
        chk(busy, 1'b0);
        @(posedge clk) #2;
        win = 1'b1;
        repeat (2) @(posedge clk);
        chk(busy, 1'b1);
        tick(2'h1);
    endtask : start

    task automatic run_seq(input logic s, input logic e);
        int n;
        int k;
        int t;
        logic [15:0] w;
        logic [15:0] q[$];
        do_reset();
        sy = s;
        ex = e;
        slow = ~s;
        n = e ? 48 : 32;
        k = s ? 4 : 8;
        start();
        for (int j = 0; j < 2 * k * n; j++) begin
            w = ew(j, k);
            q.push_back(w);
            tick(2'h0);
            if (s) begin
                q.push_back(w | 16'h0001);
                tick(2'h1);
                tick(2'h2);
            end else begin
                tick(2'h1);
            end
        end
        tick(2'h0);
        for (t = 0; t < 20 && done !== 1'b1; t++) @(posedge clk);
        chk(done, 1'b1);
        if (done !== 1'b1) final_report();
        chk(busy, 1'b0);
        chk(rx.got.size(), q.size());
        foreach (q[i]) begin
            if (i < rx.got.size()) chk({3'h0, rx.got[i]}, q[i]);
        end
        $display("test sequence sync=%0d ext=%0d finished", s, e);
    endtask : run_seq

    task automatic miss_test;
        do_reset();
        sy = 1'b0;
        ex = 1'b0;
        stall = 1'b1;
        start();
        repeat (12) tick(2'h0);
        chk(missed, 1'b1);
        chk(rx.got.size(), 0);
        stall = 1'b0;
        repeat (40) @(posedge clk);
        chk(rx.got.size() >= 8, 1'b1);
        foreach (rx.got[i]) chk({3'h0, rx.got[i]}, ew(i, 8));
        $display("test stall finished");
    endtask : miss_test

    task automatic abort_test;
        do_reset();
        det = 1'b1;
        @(posedge clk) #2;
        win = 1'b1;
        repeat (3) @(posedge clk);
        chk(aborted, 1'b1);
        tick(2'h0);
        repeat (3) @(posedge clk);
        chk(busy, 1'b0);
        chk(tx_valid, 1'b0);
        det = 1'b0;
        $display("test abort finished");
    endtask : abort_test

    initial begin
        run_seq(1'b0, 1'b0);
        run_seq(1'b1, 1'b1);
        miss_test();
        abort_test();
        final_report();
    end
endmodule : tb_top
